// >>> hw/bcl_pkg.sv
`default_nettype none
package bcl_pkg;
	localparam logic [7:0] BCL_OP_STATUS = 8'h05;
	localparam logic [7:0] BCL_OP_STATUS_ALT = 8'hd7;
	localparam logic [7:0] BCL_OP_RST_ENABLE = 8'h66;
	localparam logic [7:0] BCL_OP_RST_EXEC = 8'h99;
	localparam logic [7:0] BCL_OP_RST_ALT = 8'hf0;
	localparam logic [7:0] BCL_OP_READ3 = 8'h03;
	localparam logic [7:0] BCL_OP_READ4 = 8'h13;
	localparam int BCL_BUSY_BIT = 0;
	localparam int BCL_READY_BIT_ALT = 7;
	localparam logic [15:0] BCL_SETTLE_CYCLES = 16'h0003;
	localparam logic [31:0] BCL_WORD_BYTES = 32'h0000_0004;
	localparam int BCL_ERR_SLAVE = 0;
	localparam int BCL_ERR_VERIFY = 1;
	localparam logic [15:0] BCL_DEF_DEST_HIGH = 16'h4000;
	localparam logic [15:0] BCL_DEF_DEST_LOW = 16'h0000;
	localparam int BCL_DEF_POR_CYCLES = 1000;
	localparam int BCL_DEF_WORD_COUNT = 8192;
	localparam int BCL_DEF_RECOVERY = 8;
	localparam int BCL_DEF_CLK_RATIO = 4;
	localparam int BCL_DEF_DESELECT = 8;
	localparam logic [7:0] BCL_DEF_EEPROM_ADDR = 8'h50;
	localparam logic [7:0] BCL_DEF_PRESCALE = 8'h63;

	typedef enum logic [3:0] {BR_IDLE, BR_HWREC, BR_POLL, BR_SWR2, BR_SWREC,
		BR_READ, BR_PUSH, BR_XFER, BR_DESEL, BR_STREAM, BR_DONE} bcl_rd_t;
	typedef enum logic [3:0] {BW_IDLE, BW_WAIT, BW_SETUP, BW_ACCESS,
		BW_RBSET, BW_RBACC, BW_HOLD, BW_RUN, BW_FAIL} bcl_wr_t;

	typedef struct packed {
		logic byp1;
		logic byp;
		logic req1;
		logic req;
		logic sdi1;
		logic sdi;
		bcl_rd_t r_state;
		bcl_rd_t r_ret;
		logic [15:0] r_cnt;
		logic [15:0] div;
		logic [6:0] bits;
		logic [39:0] sh_out;
		logic [31:0] sh_in;
		logic [31:0] fl_addr;
		logic [18:0] r_left;
		logic [1:0] nbytes;
		logic all_done;
		logic strm_rdy;
		logic sck;
		logic mosi;
		logic cs_n;
		bcl_wr_t w_state;
		logic [15:0] w_cnt;
		logic [18:0] w_left;
		logic [31:0] paddr;
		logic psel;
		logic penable;
		logic pwrite;
		logic [31:0] pwdata;
		logic [31:0] first;
		logic [1:0] err;
		logic proc_rst_n;
		logic cpu_block;
		logic port_block;
	} bcl_state_t;
endpackage : bcl_pkg
`default_nettype wire

// >>> hw/bcl_loader.sv
`default_nettype none
module bcl_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 8
) (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_idx;
	logic [AW-1:0] rd_idx;
	logic [AW:0] fill;
	logic push;
	logic pop;

	assign in_ready_o = (fill != (AW+1)'(DEPTH));
	assign out_valid_o = (fill != '0);
	assign out_data_o = mem[rd_idx];
	assign push = in_valid_i && in_ready_o;
	assign pop = out_valid_o && out_ready_i;

	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
		begin
			wr_idx <= '0;
			rd_idx <= '0;
			fill <= '0;
		end
		else
		begin
			if (push)
			begin
				mem[wr_idx] <= in_data_i;
				wr_idx <= (wr_idx == AW'(DEPTH - 1)) ? '0 : wr_idx + 1'b1;
			end
			if (pop)
				rd_idx <= (rd_idx == AW'(DEPTH - 1)) ? '0 : rd_idx + 1'b1;
			if (push && !pop)
				fill <= fill + 1'b1;
			else if (pop && !push)
				fill <= fill - 1'b1;
		end
	end
endmodule : bcl_fifo

module bcl_loader import bcl_pkg::*; #(
	parameter bit LOADER_ENABLE = 1'b0,
	parameter int BOOT_SOURCE = 0,
	parameter logic [15:0] DEST_ADDR_HIGH = BCL_DEF_DEST_HIGH,
	parameter logic [15:0] DEST_ADDR_LOW = BCL_DEF_DEST_LOW,
	parameter int POR_CYCLES = BCL_DEF_POR_CYCLES,
	parameter int COPY_WORD_COUNT = BCL_DEF_WORD_COUNT,
	parameter logic [15:0] FLASH_SRC_ADDR_HIGH = 16'h0000,
	parameter logic [15:0] FLASH_SRC_ADDR_LOW = 16'h0000,
	parameter int RECOVERY_CYCLES = BCL_DEF_RECOVERY,
	parameter int FLASH_CLK_RATIO = BCL_DEF_CLK_RATIO,
	parameter int DESELECT_CYCLES = BCL_DEF_DESELECT,
	parameter bit ALT_STATUS_READ = 1'b0,
	parameter int FLASH_SOFT_RESET_KIND = 0,
	parameter bit WIDE_FLASH_ADDRESS = 1'b0,
	parameter logic [7:0] EEPROM_DEVICE_ADDRESS = BCL_DEF_EEPROM_ADDR,
	parameter bit EEPROM_TWO_BYTE_ADDR = 1'b1,
	parameter logic [7:0] EEPROM_ADDR_HIGH = 8'h00,
	parameter logic [7:0] EEPROM_ADDR_LOW = 8'h00,
	parameter logic [7:0] TWO_WIRE_PRESCALE = BCL_DEF_PRESCALE,
	parameter bit TWO_WIRE_ENABLE = 1'b1,
	parameter int FIFO_DEPTH = 8
) (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic bypass_i,
	input wire logic system_reset_request_i,
	output logic processor_reset_n_o,
	output logic processor_access_block_o,
	output logic loader_port_block_o,
	output logic flash_clk_o,
	output logic flash_data_out_o,
	output logic flash_select_n_o,
	input wire logic flash_data_in_i,
	input wire logic src_byte_valid_i,
	input wire logic [7:0] src_byte_i,
	output logic src_byte_ready_o,
	output logic [7:0] eeprom_device_address_o,
	output logic [15:0] eeprom_start_addr_o,
	output logic [7:0] two_wire_prescale_o,
	output logic two_wire_enable_o,
	output logic [31:0] paddr_o,
	output logic psel_o,
	output logic penable_o,
	output logic pwrite_o,
	output logic [31:0] pwdata_o,
	input wire logic [31:0] prdata_i,
	input wire logic pready_i,
	input wire logic pslverr_i,
	output logic [1:0] error_o
);
	localparam logic [15:0] HALF = (FLASH_CLK_RATIO < 2) ? 16'h0001 :
		16'(FLASH_CLK_RATIO / 2);
	localparam logic [15:0] PERIOD = (FLASH_CLK_RATIO < 2) ? 16'h0002 :
		16'(FLASH_CLK_RATIO);
	localparam logic [31:0] DEST_BASE = {DEST_ADDR_HIGH, DEST_ADDR_LOW};
	localparam logic [31:0] FLASH_BASE =
		{FLASH_SRC_ADDR_HIGH, FLASH_SRC_ADDR_LOW};
	localparam logic [18:0] WORDS = 19'(COPY_WORD_COUNT);
	localparam logic [15:0] POR = 16'(POR_CYCLES);
	localparam logic [15:0] RECOV = 16'(RECOVERY_CYCLES);
	localparam logic [15:0] DESEL = 16'(DESELECT_CYCLES);
	localparam bit RUN_COPY = LOADER_ENABLE;

	bcl_state_t st;
	bcl_state_t next_st;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic [31:0] fifo_out_data;
	logic push_valid;
	logic pop_ready;
	logic [31:0] push_data;
	logic fifo_clear;

	function automatic logic [31:0] bswap(input logic [31:0] w);
		bswap = {w[7:0], w[15:8], w[23:16], w[31:24]};
	endfunction : bswap

	function automatic bcl_state_t start_xfer(input bcl_state_t s,
		input logic [39:0] out, input logic [6:0] nbits, input bcl_rd_t ret);
		bcl_state_t t;
		t = s;
		t.sh_out = out;
		t.bits = nbits;
		t.div = '0;
		t.cs_n = 1'b0;
		t.sck = 1'b0;
		t.mosi = out[39];
		t.r_ret = ret;
		t.r_state = BR_XFER;
		start_xfer = t;
	endfunction : start_xfer

	function automatic bcl_state_t reset_val(input bcl_state_t s);
		bcl_state_t t;
		t = '0;
		t.byp1 = s.byp1;
		t.byp = s.byp;
		t.req1 = s.req1;
		t.req = s.req;
		t.sdi1 = s.sdi1;
		t.sdi = s.sdi;
		t.r_state = BR_IDLE;
		t.r_ret = BR_IDLE;
		t.w_state = BW_IDLE;
		t.cs_n = 1'b1;
		t.fl_addr = FLASH_BASE;
		t.r_left = WORDS;
		t.w_left = WORDS;
		t.paddr = DEST_BASE;
		t.cpu_block = 1'b1;
		t.proc_rst_n = 1'b0;
		reset_val = t;
	endfunction : reset_val

	bcl_fifo #(.WIDTH(32), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk_i(clk_i),
		.sys_rst_i(fifo_clear),
		.in_valid_i(push_valid),
		.in_ready_o(fifo_in_ready),
		.in_data_i(push_data),
		.out_valid_o(fifo_out_valid),
		.out_ready_i(pop_ready),
		.out_data_o(fifo_out_data)
	);

	// Restart must not leave stale words for the writer
	assign fifo_clear = sys_rst_i || st.req;
	assign push_valid = (st.r_state == BR_PUSH);
	// Flash words arrive first byte in the top lane
	assign push_data = (BOOT_SOURCE == 0) ? bswap(st.sh_in) : st.sh_in;
	assign pop_ready = (st.w_state == BW_WAIT) && (st.w_left != '0);

	always_comb
	begin
		next_st = st;
		next_st.byp1 = bypass_i;
		next_st.byp = st.byp1;
		next_st.req1 = system_reset_request_i;
		next_st.req = st.req1;
		next_st.sdi1 = flash_data_in_i;
		next_st.sdi = st.sdi1;

		// Reader side
		case (st.r_state)
			BR_IDLE:
			begin
				if (st.r_cnt != BCL_SETTLE_CYCLES)
					next_st.r_cnt = st.r_cnt + 16'h0001;
				else if (RUN_COPY && !st.byp)
				begin
					if (BOOT_SOURCE == 0)
					begin
						next_st.r_state = BR_HWREC;
						next_st.r_cnt = RECOV;
					end
					else
						next_st.r_state = BR_STREAM;
				end
			end
			BR_HWREC:
			begin
				if (st.r_cnt > 16'h0001)
					next_st.r_cnt = st.r_cnt - 16'h0001;
				else
					next_st = start_xfer(st, {ALT_STATUS_READ ? BCL_OP_STATUS_ALT :
						BCL_OP_STATUS, 32'h0}, 7'd16, BR_POLL);
			end
			BR_POLL:
			begin
				if (ALT_STATUS_READ ? !st.sh_in[BCL_READY_BIT_ALT] :
					st.sh_in[BCL_BUSY_BIT])
					next_st = start_xfer(st, {ALT_STATUS_READ ? BCL_OP_STATUS_ALT
						: BCL_OP_STATUS, 32'h0}, 7'd16, BR_POLL);
				else
					case (FLASH_SOFT_RESET_KIND)
						1: next_st = start_xfer(st, {BCL_OP_RST_ENABLE, 32'h0}, 7'd8,
							BR_SWR2);
						2: next_st = start_xfer(st, {BCL_OP_RST_ALT, 32'h0}, 7'd32,
							BR_SWREC);
						3: next_st = start_xfer(st, {BCL_OP_RST_ALT, 32'h0}, 7'd8,
							BR_SWREC);
						default: next_st.r_state = BR_READ;
					endcase
			end
			BR_SWR2:
				next_st = start_xfer(st, {BCL_OP_RST_EXEC, 32'h0}, 7'd8,
					BR_SWREC);
			BR_SWREC:
			begin
				if (st.r_cnt > 16'h0001)
					next_st.r_cnt = st.r_cnt - 16'h0001;
				else
					next_st.r_state = BR_READ;
			end
			BR_READ:
			begin
				if (st.r_left == '0)
					next_st.r_state = BR_DONE;
				else if (WIDE_FLASH_ADDRESS)
					next_st = start_xfer(st, {BCL_OP_READ4, st.fl_addr}, 7'd72,
						BR_PUSH);
				else
					next_st = start_xfer(st, {BCL_OP_READ3, st.fl_addr[23:0],
						8'h00}, 7'd64, BR_PUSH);
			end
			BR_XFER:
			begin
				// One bit per ratio period, mode 0 timing
				next_st.div = (st.div == PERIOD - 16'h0001) ? '0 :
					st.div + 16'h0001;
				next_st.sck = (next_st.div >= HALF);
				if (st.div == PERIOD - 16'h0001)
				begin
					next_st.sh_in = {st.sh_in[30:0], st.sdi};
					next_st.sh_out = {st.sh_out[38:0], 1'b0};
					next_st.mosi = st.sh_out[38];
					next_st.bits = st.bits - 7'd1;
					if (st.bits == 7'd1)
					begin
						next_st.cs_n = 1'b1;
						next_st.sck = 1'b0;
						next_st.mosi = 1'b0;
						next_st.r_cnt = DESEL;
						next_st.r_state = BR_DESEL;
					end
				end
			end
			BR_DESEL:
			begin
				if (st.r_cnt > 16'h0001)
					next_st.r_cnt = st.r_cnt - 16'h0001;
				else
				begin
					next_st.r_cnt = RECOV;
					next_st.r_state = st.r_ret;
				end
			end
			BR_STREAM:
			begin
				if (st.r_left == '0)
					next_st.r_state = BR_DONE;
				else if (st.strm_rdy && src_byte_valid_i)
				begin
					next_st.sh_in = {src_byte_i, st.sh_in[31:8]};
					next_st.nbytes = st.nbytes + 2'd1;
					if (st.nbytes == 2'd3)
						next_st.r_state = BR_PUSH;
				end
			end
			BR_PUSH:
			begin
				if (fifo_in_ready)
				begin
					next_st.r_left = st.r_left - 19'd1;
					next_st.fl_addr = st.fl_addr + BCL_WORD_BYTES;
					next_st.r_state = (BOOT_SOURCE == 0) ? BR_READ : BR_STREAM;
				end
			end
			BR_DONE:
				next_st.all_done = 1'b1;
			default:
				next_st.r_state = BR_IDLE;
		endcase
		next_st.strm_rdy = (next_st.r_state == BR_STREAM) &&
			(next_st.r_left != '0);

		// Writer side
		case (st.w_state)
			BW_IDLE:
			begin
				if (st.w_cnt != BCL_SETTLE_CYCLES)
					next_st.w_cnt = st.w_cnt + 16'h0001;
				else if (RUN_COPY && !st.byp)
					next_st.w_state = BW_WAIT;
				else
				begin
					next_st.cpu_block = 1'b0;
					next_st.port_block = 1'b1;
					next_st.w_cnt = POR;
					next_st.w_state = BW_HOLD;
				end
			end
			BW_WAIT:
			begin
				if (st.w_left == '0)
				begin
					if (st.all_done)
					begin
						next_st.paddr = DEST_BASE;
						next_st.w_cnt = POR;
						next_st.psel = (WORDS != '0);
						next_st.pwrite = 1'b0;
						next_st.w_state = (WORDS != '0) ? BW_RBSET : BW_HOLD;
					end
				end
				else if (fifo_out_valid)
				begin
					next_st.pwdata = fifo_out_data;
					if (st.w_left == WORDS)
						next_st.first = fifo_out_data;
					next_st.psel = 1'b1;
					next_st.pwrite = 1'b1;
					next_st.w_state = BW_SETUP;
				end
			end
			BW_SETUP:
			begin
				next_st.penable = 1'b1;
				next_st.w_state = BW_ACCESS;
			end
			BW_ACCESS:
			begin
				if (pready_i)
				begin
					next_st.psel = 1'b0;
					next_st.penable = 1'b0;
					next_st.pwrite = 1'b0;
					if (pslverr_i)
					begin
						next_st.err[BCL_ERR_SLAVE] = 1'b1;
						next_st.w_state = BW_FAIL;
					end
					else
					begin
						next_st.w_left = st.w_left - 19'd1;
						next_st.paddr = st.paddr + BCL_WORD_BYTES;
						next_st.w_state = BW_WAIT;
					end
				end
			end
			BW_RBSET:
			begin
				next_st.penable = 1'b1;
				next_st.w_state = BW_RBACC;
			end
			BW_RBACC:
			begin
				if (pready_i)
				begin
					next_st.psel = 1'b0;
					next_st.penable = 1'b0;
					if (pslverr_i)
					begin
						next_st.err[BCL_ERR_SLAVE] = 1'b1;
						next_st.w_state = BW_FAIL;
					end
					else
					begin
						if (prdata_i != st.first)
							next_st.err[BCL_ERR_VERIFY] = 1'b1;
						next_st.w_state = BW_HOLD;
					end
				end
			end
			BW_HOLD:
			begin
				if (st.w_cnt > 16'h0001)
					next_st.w_cnt = st.w_cnt - 16'h0001;
				else
				begin
					next_st.proc_rst_n = 1'b1;
					next_st.cpu_block = 1'b0;
					next_st.port_block = 1'b1;
					next_st.w_state = BW_RUN;
				end
			end
			BW_RUN, BW_FAIL:
				next_st.w_state = st.w_state;
			default:
				next_st.w_state = BW_IDLE;
		endcase

		if (st.req)
			next_st = reset_val(next_st);
	end

	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
			st <= reset_val('0);
		else
			st <= next_st;
	end

	assign processor_reset_n_o = st.proc_rst_n;
	assign processor_access_block_o = st.cpu_block;
	assign loader_port_block_o = st.port_block;
	assign flash_clk_o = st.sck;
	assign flash_data_out_o = st.mosi;
	assign flash_select_n_o = st.cs_n;
	assign src_byte_ready_o = st.strm_rdy;
	assign paddr_o = st.paddr;
	assign psel_o = st.psel;
	assign penable_o = st.penable;
	assign pwrite_o = st.pwrite;
	assign pwdata_o = st.pwdata;
	assign error_o = st.err;

	// Build constants for the two-wire peripheral
	assign eeprom_device_address_o = EEPROM_DEVICE_ADDRESS;
	assign eeprom_start_addr_o = {EEPROM_TWO_BYTE_ADDR ? EEPROM_ADDR_HIGH :
		8'h00, EEPROM_ADDR_LOW};
	assign two_wire_prescale_o = TWO_WIRE_PRESCALE;
	assign two_wire_enable_o = TWO_WIRE_ENABLE && (BOOT_SOURCE == 1);
endmodule : bcl_loader
`default_nettype wire

// >>> hw/bcl_dummy_unused.sv
`default_nettype none
`default_nettype wire

// >>> verification/bcl_loader_asserts.sv
`default_nettype none
module bcl_loader_asserts #(
	parameter int POR_CYCLES = 4,
	parameter int FLASH_CLK_RATIO = 4,
	parameter int DESELECT_CYCLES = 8
) (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic system_reset_request_i,
	input wire logic processor_reset_n_o,
	input wire logic processor_access_block_o,
	input wire logic loader_port_block_o,
	input wire logic flash_clk_o,
	input wire logic flash_select_n_o,
	input wire logic [31:0] paddr_o,
	input wire logic [31:0] pwdata_o,
	input wire logic psel_o,
	input wire logic penable_o,
	input wire logic pready_i,
	input wire logic pslverr_i,
	input wire logic [1:0] error_o
);
	logic [15:0] desel_run;
	logic [15:0] sck_run;
	logic [15:0] idle_run;
	logic [15:0] sck_low;
	logic sat_d;
	logic sat_i;
	assign sat_d = desel_run != 16'hffff;
	assign sat_i = idle_run != 16'hffff;
	// Run lengths of select high, clock high, time since last APB end
	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
		begin
			desel_run <= 16'hffff;
			sck_run <= 16'h0000;
			idle_run <= 16'hffff;
			sck_low <= 16'h0000;
		end
		else
		begin
			desel_run <= flash_select_n_o ? desel_run + {15'h0, sat_d} : 16'h0;
			sck_run <= flash_clk_o ? sck_run + 16'h1 : 16'h0;
			sck_low <= (flash_clk_o || flash_select_n_o) ? 16'h0
				: sck_low + 16'h1;
			idle_run <= (psel_o && penable_o && pready_i) ? 16'h0
				: idle_run + {15'h0, sat_i};
		end
	end
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (sys_rst_i || system_reset_request_i);
	sequence s_setup;
		psel_o && !penable_o;
	endsequence
	sequence s_wait;
		psel_o && penable_o && !pready_i;
	endsequence
	sequence s_done;
		psel_o && penable_o && pready_i;
	endsequence
	a_copy_holds_cpu: assert property (
		psel_o |-> !processor_reset_n_o && processor_access_block_o
		&& !loader_port_block_o) else $error("cpu not held in copy");
	a_setup_to_access: assert property (
		s_setup |=> psel_o && penable_o && $stable(paddr_o)
		&& $stable(pwdata_o)) else $error("bad access phase");
	a_wait_holds: assert property (
		s_wait |=> psel_o && penable_o && $stable(paddr_o)
		&& $stable(pwdata_o)) else $error("request not held");
	a_idle_after: assert property (
		s_done |=> !psel_o) else $error("no idle cycle");
	a_slverr_flags: assert property (
		s_done ##0 pslverr_i |=> error_o[0]) else $error("error bit 0 missed");
	a_slverr_abort: assert property (
		error_o[0] |-> !psel_o && !processor_reset_n_o)
		else $error("copy goes on after error");
	a_release_together: assert property (
		$rose(processor_reset_n_o) |-> !processor_access_block_o
		&& loader_port_block_o) else $error("release not together");
	a_release_delay: assert property (
		$rose(processor_reset_n_o) |-> idle_run >= POR_CYCLES)
		else $error("release too early");
	a_cpu_exclusive: assert property (
		!processor_access_block_o |-> !psel_o) else $error("copy with cpu on");
	a_select_gap: assert property (
		$fell(flash_select_n_o) |-> desel_run >= DESELECT_CYCLES)
		else $error("deselect too short");
	a_sclk_half: assert property (
		$fell(flash_clk_o) |-> sck_run == FLASH_CLK_RATIO / 2)
		else $error("serial clock high time wrong");
	a_sclk_low: assert property (
		$rose(flash_clk_o) |->
		sck_low == FLASH_CLK_RATIO - FLASH_CLK_RATIO / 2)
		else $error("serial clock low time wrong");
endmodule : bcl_loader_asserts
`default_nettype wire

// >>> verification/bcl_flash_model.sv
`default_nettype none
module bcl_flash_model import bcl_pkg::*; (
	input wire logic sclk_i,
	input wire logic cs_n_i,
	input wire logic mosi_i,
	output logic miso_o
);
	logic [31:0] sh;
	logic [7:0] op;
	logic [23:0] adr;
	logic [23:0] t;
	logic [7:0] b;
	int cnt;
	int polls;
	int k;
	initial
	begin
		miso_o = 1'b0;
		cnt = 0;
		polls = 0;
		op = 8'h00;
	end
	always @(negedge cs_n_i)
		cnt = 0;
	// Releasing the select inverts the last bit on the line
	always @(posedge cs_n_i)
		miso_o = ~miso_o;
	always @(posedge sclk_i)
	begin
		if (!cs_n_i)
		begin
			sh = {sh[30:0], mosi_i};
			cnt++;
			if (cnt == 8)
			begin
				op = sh[7:0];
				if (op == BCL_OP_STATUS)
					polls++;
			end
			if (cnt == 32)
				adr = sh[23:0];
		end
	end
	always @(negedge sclk_i)
	begin
		if (!cs_n_i && cnt >= 8 && op == BCL_OP_STATUS)
			miso_o = (polls == 1) && (cnt == 15);
		else if (!cs_n_i && cnt >= 32 && op == BCL_OP_READ3)
		begin
			k = cnt - 32;
			t = adr + 24'(k / 8);
			b = t[7:0] ^ t[23:16] ^ 8'h5a;
			miso_o = b[7 - k % 8];
		end
	end
endmodule : bcl_flash_model
`default_nettype wire

// >>> verification/bcl_loader_tb_top.sv
`default_nettype none
`define CHK(g, e) \
	begin \
		checks_done++; \
		if ((g) !== (e)) \
		begin \
			n_fail++; \
			$display("unexpected at %0t: %h vs %h", $time, g, e); \
		end \
	end
module bcl_loader_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int WORDS = 4;
	localparam logic [31:0] DEST = 32'h4000_0080;
	localparam logic [31:0] SRC = 32'h0001_0100;
	localparam int POR = 4;
	localparam int DESEL = 2;
	localparam int RATIO = 4;
	logic clk_i, sys_rst_i, bypass_i, system_reset_request_i;
	logic processor_reset_n_o, processor_access_block_o, loader_port_block_o;
	logic flash_clk_o, flash_data_out_o, flash_select_n_o, flash_data_in_i;
	logic psel_o, penable_o, pwrite_o, pready_i, pslverr_i;
	logic [31:0] paddr_o, pwdata_o, prdata_i, corrupt;
	logic [1:0] error_o;
	logic [7:0] dev_addr, prescale, src_byte;
	logic [15:0] eep_start;
	logic src_vld, src_rdy, tw_en;
	logic [63:0] exp_w;
	logic [63:0] expq[$];
	logic [31:0] mem[logic [31:0]];
	integer seed = 32'hd8c7;
	int n_fail, checks_done, n_wr, n_rd, wait_left, err_idx;
	bcl_loader #(.LOADER_ENABLE(1'b1), .BOOT_SOURCE(0),
		.DEST_ADDR_LOW(DEST[15:0]), .POR_CYCLES(POR),
		.COPY_WORD_COUNT(WORDS),
		.FLASH_SRC_ADDR_HIGH(SRC[31:16]), .FLASH_SRC_ADDR_LOW(SRC[15:0]),
		.DESELECT_CYCLES(DESEL), .FLASH_CLK_RATIO(RATIO)) dut (
		.clk_i(clk_i), .sys_rst_i(sys_rst_i), .bypass_i(bypass_i),
		.system_reset_request_i(system_reset_request_i),
		.processor_reset_n_o(processor_reset_n_o),
		.processor_access_block_o(processor_access_block_o),
		.loader_port_block_o(loader_port_block_o),
		.flash_clk_o(flash_clk_o), .flash_data_out_o(flash_data_out_o),
		.flash_select_n_o(flash_select_n_o),
		.flash_data_in_i(flash_data_in_i), .src_byte_valid_i(src_vld),
		.src_byte_i(src_byte), .src_byte_ready_o(src_rdy),
		.eeprom_device_address_o(dev_addr),
		.eeprom_start_addr_o(eep_start),
		.two_wire_prescale_o(prescale), .two_wire_enable_o(tw_en),
		.paddr_o(paddr_o), .psel_o(psel_o), .penable_o(penable_o),
		.pwrite_o(pwrite_o), .pwdata_o(pwdata_o), .prdata_i(prdata_i),
		.pready_i(pready_i), .pslverr_i(pslverr_i), .error_o(error_o));
	bcl_flash_model flash (.sclk_i(flash_clk_o), .cs_n_i(flash_select_n_o),
		.mosi_i(flash_data_out_o), .miso_o(flash_data_in_i));
	initial
	begin
		clk_i = 1'b0;
		forever #20 clk_i = ~clk_i;
	end
	// Memory target with random wait states
	always @(negedge clk_i)
	begin
		if (psel_o && penable_o && !pready_i && wait_left == 0)
		begin
			pready_i <= 1'b1;
			pslverr_i <= pwrite_o && (n_wr == err_idx);
			prdata_i <= mem.exists(paddr_o) ? mem[paddr_o] ^ corrupt : 32'h0;
			if (pwrite_o)
				mem[paddr_o] = pwdata_o;
			wait_left = $unsigned($random(seed)) % 3;
		end
		else
		begin
			pready_i <= 1'b0;
			pslverr_i <= 1'b0;
			if (psel_o && penable_o && !pready_i)
				wait_left--;
		end
	end
	// Byte stream noise, must be ignored in flash mode
	always @(negedge clk_i)
		{src_vld, src_byte} <= 9'($random(seed));
	always @(posedge clk_i)
	begin
		if (psel_o && penable_o && pready_i && pwrite_o)
		begin
			n_wr++;
			exp_w = (expq.size() > 0) ? expq.pop_front() : 64'h0;
			`CHK({paddr_o, pwdata_o}, exp_w)
		end
		else if (psel_o && penable_o && pready_i)
		begin
			n_rd++;
			`CHK(paddr_o, DEST)
		end
	end
	function automatic logic [31:0] word_at(input logic [31:0] a);
		logic [31:0] t;
		for (int i = 0; i < 4; i++)
		begin
			t = a + 32'(i);
			word_at[8*i +: 8] = t[7:0] ^ t[23:16] ^ 8'h5a;
		end
	endfunction : word_at
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : tally_and_finish
	task automatic start(input logic byp, input int eidx,
		input logic [31:0] bad);
		@(negedge clk_i);
		bypass_i = byp;
		system_reset_request_i = 1'b1;
		repeat (4) @(negedge clk_i);
		err_idx = eidx;
		corrupt = bad;
		n_wr = 0;
		n_rd = 0;
		expq.delete();
		for (int k = 0; k < WORDS && !byp; k++)
			expq.push_back({DEST + 32'(4 * k), word_at(SRC + 32'(4 * k))});
		system_reset_request_i = 1'b0;
		repeat (4) @(negedge clk_i);
		`CHK({processor_reset_n_o, error_o}, 3'b000)
	endtask : start
	task automatic wait_cond(input int mode);
		int i;
		i = 0;
		while (mode ? n_wr < 2
			: processor_reset_n_o !== 1'b1 && error_o[0] !== 1'b1)
		begin
			@(negedge clk_i);
			i++;
			if (i > 20000)
			begin
				n_fail++;
				$display("unexpected at %0t: wait ran out", $time);
				tally_and_finish();
			end
		end
	endtask : wait_cond
	initial
	begin
		sys_rst_i = 1'b1;
		bypass_i = 1'b0;
		system_reset_request_i = 1'b0;
		pready_i = 1'b0;
		pslverr_i = 1'b0;
		prdata_i = 32'h0;
		n_fail = 0;
		checks_done = 0;
		wait_left = 0;
		err_idx = -1;
		corrupt = 32'h0;
		repeat (12) @(negedge clk_i);
		`CHK({processor_reset_n_o, processor_access_block_o, loader_port_block_o,
			flash_select_n_o, psel_o, error_o}, 7'b0101000)
		`CHK({dev_addr, prescale}, 16'h5063)
		sys_rst_i = 1'b0;
		// Restart after two words, then a full boot
		start(1'b0, -1, 32'h0);
		wait_cond(1);
		start(1'b0, -1, 32'h0);
		wait_cond(0);
		`CHK({n_wr, n_rd}, {32'(WORDS), 32'd1})
		`CHK({processor_access_block_o, loader_port_block_o, error_o},
			4'b0100)
		`CHK({src_rdy, tw_en, eep_start}, 18'h0)
		// First word reads back different
		start(1'b0, -1, $random(seed) | 32'h1);
		wait_cond(0);
		`CHK({processor_reset_n_o, error_o}, 3'b110)
		// Target refuses the second write
		start(1'b0, 1, 32'h0);
		wait_cond(0);
		repeat (300) @(negedge clk_i);
		`CHK({processor_reset_n_o, error_o, n_wr}, {3'b001, 32'd2})
		// Copy skipped
		start(1'b1, -1, 32'h0);
		repeat (200) @(negedge clk_i);
		`CHK({processor_reset_n_o, processor_access_block_o, loader_port_block_o,
			n_wr, n_rd}, {3'b101, 64'h0})
		tally_and_finish();
	end
endmodule : bcl_loader_tb_top
bind bcl_loader bcl_loader_asserts #(.POR_CYCLES(POR_CYCLES),
	.FLASH_CLK_RATIO(FLASH_CLK_RATIO), .DESELECT_CYCLES(DESELECT_CYCLES)) u_chk (
	.clk_i(clk_i), .sys_rst_i(sys_rst_i),
	.system_reset_request_i(system_reset_request_i),
	.processor_reset_n_o(processor_reset_n_o),
	.processor_access_block_o(processor_access_block_o),
	.loader_port_block_o(loader_port_block_o), .flash_clk_o(flash_clk_o),
	.flash_select_n_o(flash_select_n_o), .paddr_o(paddr_o),
	.pwdata_o(pwdata_o), .psel_o(psel_o), .penable_o(penable_o),
	.pready_i(pready_i), .pslverr_i(pslverr_i), .error_o(error_o));
`undef CHK
`default_nettype wire
